//--- src/custom_tx_pulse_shaper.sv
// Purpose: Custom mark pulse amplitude registers and phase sequencer
// Assumes: AXI4-Lite slave, single clock, synchronous active-low reset
// Notes:   Template codes arrive on a port from the template store
`timescale 1ns/100ps
`include "pulse_shaper_cfg.svh"

// Register map, byte addresses on the AXI4-Lite port
//   0x70  phase one amplitude code, bits 6..0
//   0x74  phase two amplitude code, bits 6..0
//   0x78  phase three amplitude code, bits 6..0
//   0x7c  phase four amplitude code, bits 6..0
//   0x44  pulse enable, select bit 3
//   0x80  mark start, write one to bit 0, reads zero
//   0x84  status, read only
// Byte address is four times the register index
// Status word layout
//   bit 8     mark pending
//   bit 7     converter word valid
//   bits 6..5 phase being driven
//   bit 0     select bit copy
// Other status bits read zero
// Write channel
//   Address and data are taken in either order
//   Each side is held until the other arrives
//   Response rises the cycle after both are held
//   Ready drops while one side waits or a response stands
// Read channel
//   Data is registered the cycle after the address is taken
//   Ready drops while read data stands
// Unmapped addresses answer with a slave error
//   A write to them changes nothing
//   A read from them returns zero
// Only the low byte lane carries register bits
//   Strobes are not looked at; every write is a full write
// Bit 7 of each phase register is stored and read back
//   It never reaches the converter
// Mark sequencing
//   A strobe or a mark start write sets a pending flag
//   The sequencer leaves idle on the next edge
//   Each phase lasts a fixed count of cycles
//   The four phases go out in order, then one idle cycle
//   Strobes during a mark fold into one pending mark
//   A level held high gives back to back marks
//   Sequencer states follow a Gray path
//   so one state bit moves per step, but two on the step from phase four back to idle
// Converter word
//   Valid, phase index and code all come from flip-flops
//   Code is the programmed value while select is high
//   Otherwise the template slice for that phase
//   Select is looked at every cycle, so a change mid mark
//   takes effect from the next cycle on
// Reset
//   Synchronous and active low; all registered outputs clear
//   Ready outputs are high once reset is applied
// Hazards
//   No reset values are defined for the codes; zero is used
//   Software must program codes before setting select
//   Template codes are expected to be stable while in use
// Timing
//   A strobe seen on one edge sets pending
//   Phase one is driven from the next edge after it
//   Sixteen cycles of valid per mark with the default count

// Behaviour
// - Phase one of each mark uses register 1CH bits 6..0.
// - Phase two of each mark uses register 1DH bits 6..0.
// - Phase three of each mark uses register 1EH bits 6..0.
// - Phase four of each mark uses register 1FH bits 6..0.
// - Code is unsigned magnitude; larger value drives larger amplitude.
// - Programmed codes apply only while select bit 3 at 11H is high.
// - With select low, phase codes come from the template store.
module custom_tx_pulse_shaper
    import pulse_shaper_pkg::*;
(
    input  wire logic        aclk,          // Transmit line clock
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [7:0]  awaddr,        // Write address
    input  wire logic        awvalid,       // Write address valid
    output logic             awready,       // Write address ready
    input  wire logic [31:0] wdata,         // Write data
    input  wire logic [3:0]  wstrb,         // Write byte strobes
    input  wire logic        wvalid,        // Write data valid
    output logic             wready,        // Write data ready
    output logic [1:0]       bresp,         // Write response
    output logic             bvalid,        // Write response valid
    input  wire logic        bready,        // Write response ready
    input  wire logic [7:0]  araddr,        // Read address
    input  wire logic        arvalid,       // Read address valid
    output logic             arready,       // Read address ready
    output logic [31:0]      rdata,         // Read data
    output logic [1:0]       rresp,         // Read response
    output logic             rvalid,        // Read data valid
    input  wire logic        rready,        // Read data ready
    input  wire logic        mark_strobe,   // Pulse: transmit a mark
    input  wire logic [27:0] template_codes,// Template codes, phase1 low
    output dac_word_t        dac_out        // Word to the converter
);

    // Phase code registers and the enable register
    logic [7:0]   phase_q [4];
    logic [7:0]   phase_d [4];
    logic [7:0]   enable_q, enable_d;

    // Write channel holding state
    logic [7:0]   aw_addr_q, aw_addr_d;
    logic         aw_have_q, aw_have_d;
    logic [31:0]  w_data_q, w_data_d;
    logic         w_have_q, w_have_d;
    logic [1:0]   bresp_q, bresp_d;
    logic         bvalid_q, bvalid_d;

    // Read channel state
    logic [31:0]  rdata_q, rdata_d;
    logic [1:0]   rresp_q, rresp_d;
    logic         rvalid_q, rvalid_d;

    // Sequencer state and converter word
    phase_state_t state_q, state_d;
    logic [7:0]   cnt_q, cnt_d;
    logic         pending_q, pending_d;
    dac_word_t    dac_q, dac_d;

    // Internal nets
    logic [6:0]   code_sel [4];
    logic         do_write;
    logic         sw_mark;
    logic         sel_on;

    // Bus and converter outputs, select and write decodes
    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign bresp   = bresp_q;
    assign bvalid  = bvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    assign rvalid  = rvalid_q;
    assign dac_out = dac_q;
    assign sel_on  = enable_q[`SELECT_BIT];
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign sw_mark = do_write && aw_addr_q == `ADDR_MARK_CTRL
                     && w_data_q[`MARK_START_BIT];

    // Per-phase code source: programmed or template
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
            assign code_sel[gi] = sel_on
                ? phase_q[gi][`CODE_MSB:0]
                : template_codes[gi*7 +: 7];
        end
    endgenerate

    // Bus write path, register updates and read path
    always_comb begin
        aw_addr_d = aw_addr_q;
        aw_have_d = aw_have_q;
        w_data_d  = w_data_q;
        w_have_d  = w_have_q;
        bresp_d   = bresp_q;
        bvalid_d  = bvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        rvalid_d  = rvalid_q;
        enable_d  = enable_q;
        for (int i = 0; i < 4; i++) begin
            phase_d[i] = phase_q[i];
        end
        if (awvalid && awready) begin
            aw_addr_d = awaddr;
            aw_have_d = 1'b1;
        end
        if (wvalid && wready) begin
            w_data_d = wdata;
            w_have_d = 1'b1;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = 2'h0;
            // Low byte lane carries every register here
            if (aw_addr_q[7:4] == 4'(`ADDR_PHASE1 >> 4)
                && aw_addr_q[1:0] == 2'h0 && aw_addr_q[3:2] <= 2'h3) begin
                // Bit 7 is stored as written; software keeps it zero
                phase_d[aw_addr_q[3:2]] = w_data_q[7:0];
            end else if (aw_addr_q == `ADDR_PULSE_ENABLE) begin
                enable_d = w_data_q[7:0];
            end else if (aw_addr_q != `ADDR_MARK_CTRL) begin
                bresp_d = 2'h2;                     // Unmapped: SLVERR
            end
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d  = 2'h0;
            rdata_d  = 32'h0;
            if (araddr[7:4] == 4'(`ADDR_PHASE1 >> 4)
                && araddr[1:0] == 2'h0) begin
                rdata_d = {24'h0, phase_q[araddr[3:2]]};
            end else if (araddr == `ADDR_PULSE_ENABLE) begin
                rdata_d = {24'h0, enable_q};
            end else if (araddr == `ADDR_STATUS) begin
                rdata_d = {23'h0, pending_q, dac_q.valid,
                           dac_q.phase, 4'h0, sel_on};
            end else if (araddr != `ADDR_MARK_CTRL) begin
                rresp_d = 2'h2;
            end
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Phase sequencer: four phases per mark, in order
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        pending_d = pending_q || mark_strobe || sw_mark;
        dac_d     = '0;
        case (state_q)
            ST_IDLE: begin
                if (pending_q) begin
                    pending_d = mark_strobe || sw_mark;
                    state_d   = ST_PH1;
                    cnt_d     = `PHASE_CYCLES - 8'h01;
                end
            end
            ST_PH1, ST_PH2, ST_PH3, ST_PH4: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    cnt_d = `PHASE_CYCLES - 8'h01;
                    case (state_q)
                        ST_PH1:  state_d = ST_PH2;
                        ST_PH2:  state_d = ST_PH3;
                        ST_PH3:  state_d = ST_PH4;
                        default: state_d = ST_IDLE;
                    endcase
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Unsigned code passes straight to the converter
        case (state_d)
            ST_PH1:  dac_d = '{1'b1, 2'h0, code_sel[0]};
            ST_PH2:  dac_d = '{1'b1, 2'h1, code_sel[1]};
            ST_PH3:  dac_d = '{1'b1, 2'h2, code_sel[2]};
            ST_PH4:  dac_d = '{1'b1, 2'h3, code_sel[3]};
            default: dac_d = '0;
        endcase
    end

    // Write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 8'h00;
            aw_have_q <= 1'b0;
            w_data_q  <= 32'h0;
            w_have_q  <= 1'b0;
            bresp_q   <= 2'h0;
            bvalid_q  <= 1'b0;
        end else begin
            aw_addr_q <= aw_addr_d;
            aw_have_q <= aw_have_d;
            w_data_q  <= w_data_d;
            w_have_q  <= w_have_d;
            bresp_q   <= bresp_d;
            bvalid_q  <= bvalid_d;
        end
    end

    // Phase code and enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= `ENABLE_RESET;
            for (int i = 0; i < 4; i++) begin
                phase_q[i] <= `PHASE_RESET;
            end
        end else begin
            enable_q <= enable_d;
            phase_q  <= phase_d;
        end
    end

    // Read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q  <= 32'h0;
            rresp_q  <= 2'h0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Sequencer and converter word registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= ST_IDLE;
            cnt_q     <= 8'h00;
            pending_q <= 1'b0;
            dac_q     <= '0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            pending_q <= pending_d;
            dac_q     <= dac_d;
        end
    end

endmodule : custom_tx_pulse_shaper

//--- src/pulse_shaper_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: AXI4-Lite byte addresses = 4 * register index
// Notes:   Definitions only
`ifndef PULSE_SHAPER_CFG_SVH
`define PULSE_SHAPER_CFG_SVH

// Register indices as printed
`define IDX_PHASE1       8'h1c
`define IDX_PHASE2       8'h1d
`define IDX_PHASE3       8'h1e
`define IDX_PHASE4       8'h1f
`define IDX_PULSE_ENABLE 8'h11
`define IDX_MARK_CTRL    8'h20
`define IDX_STATUS       8'h21
// Byte addresses
`define ADDR_PHASE1       8'h70
`define ADDR_PULSE_ENABLE 8'h44
`define ADDR_MARK_CTRL    8'h80
`define ADDR_STATUS       8'h84
// Fields
`define CODE_MSB         6
`define SELECT_BIT       3
`define MARK_START_BIT   0
// Reset values (none documented; zero chosen)
`define PHASE_RESET      8'h00
`define ENABLE_RESET     8'h00
// Cycles per phase of a mark
`define PHASE_CYCLES     8'h04

`endif

//--- src/pulse_shaper_pkg.sv
// Purpose: Types for the custom transmit pulse shaper
// Assumes: Constants live in pulse_shaper_cfg.svh
// Notes:   None
package pulse_shaper_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PH1  = 3'b001,
        ST_PH2  = 3'b011,
        ST_PH3  = 3'b010,
        ST_PH4  = 3'b110
    } phase_state_t;

    typedef struct packed {
        logic       valid;  // Code is being driven
        logic [1:0] phase;  // Phase index 0..3
        logic [6:0] code;   // Converter amplitude code
    } dac_word_t;
endpackage : pulse_shaper_pkg

//--- testbench/custom_tx_pulse_shaper_tb.sv
// Purpose: Self-checking bench for the pulse shaper
// Assumes: Template codes stay constant
// Notes:   Registers reached over AXI4-Lite
`timescale 1ns/100ps
`include "pulse_shaper_cfg.svh"
module custom_tx_pulse_shaper_tb
    import pulse_shaper_pkg::*;
;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bready;
    logic        bvalid, arvalid, arready, rvalid, rready, mark_strobe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [27:0] template_codes;
    dac_word_t   dac_out;
    logic [3:0][6:0] codes;
    int          marks, failures, n_compared, k;
    logic [6:0]  v [4] = '{7'h7f, 7'h00, 7'h01, 7'h40};
    custom_tx_pulse_shaper custom_tx_pulse_shaper_inst (.aclk, .aresetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .mark_strobe, .template_codes, .dac_out);
    dac_model dac_model_inst (.aclk, .dac_in(dac_out), .codes, .marks);
    task check(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task report_and_stop;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task give_up;
        failures++;
        report_and_stop();
    endtask : give_up
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        resp = bresp;
        if (n == 50) give_up();
        @(posedge aclk);
    endtask : axi_wr
    task axi_rd(input logic [7:0] a);
        int n;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
        if (n == 50) give_up();
        @(posedge aclk);
    endtask : axi_rd
    task send_mark;
        int n, m0;
        m0 = marks;
        mark_strobe <= 1'b1;
        @(posedge aclk);
        mark_strobe <= 1'b0;
        for (n = 0; n < 40 && marks == m0; n++) @(posedge aclk);
        if (n == 40) give_up();
    endtask : send_mark
    // Reset values, write and read back, unmapped access
    task reg_scenario;
        for (k = 0; k < 4; k++) begin
            axi_rd(`ADDR_PHASE1 + 8'(4 * k));
            check("reset code", {24'h0, `PHASE_RESET}, rd);
            axi_wr(`ADDR_PHASE1 + 8'(4 * k), {25'h0, v[k]});
            axi_rd(`ADDR_PHASE1 + 8'(4 * k));
            check("readback", {25'h0, v[k]}, rd);
        end
        axi_rd(8'h0c);
        check("unmapped read", 32'h2, {rd[29:0], resp});
        axi_wr(8'h0c, 32'h5a);
        check("unmapped write", 32'h2, {30'h0, resp});
    endtask : reg_scenario
    // Custom codes drive every phase of a mark, checked per phase index, not in order
    task custom_scenario;
        axi_wr(`ADDR_PULSE_ENABLE, 32'h08);
        send_mark();
        for (k = 0; k < 4; k++)
            check("custom code", {25'h0, v[k]},
                  {25'h0, codes[k]});
        check("magnitude", 32'h1, {31'h0, codes[0] > codes[2]});
    endtask : custom_scenario
    // Template codes when the select bit is low
    task template_scenario;
        axi_wr(`ADDR_PULSE_ENABLE, 32'h00);
        send_mark();
        for (k = 0; k < 4; k++)
            check("template", {25'h0, template_codes[7*k +: 7]},
                  {25'h0, codes[k]});
    endtask : template_scenario
    // Status word, then a mark started by a register write
    task sw_scenario;
        int n, m0;
        axi_rd(`ADDR_STATUS);
        check("status", 32'h1, rd);
        axi_wr(`ADDR_PHASE1 + 8'h0c, 32'h2a);
        m0 = marks;
        axi_wr(`ADDR_MARK_CTRL, 32'h1);
        for (n = 0; n < 40 && marks == m0; n++) @(posedge aclk);
        if (n == 40) give_up();
        check("sw mark code", 32'h2a, {25'h0, codes[3]});
    endtask : sw_scenario
    // Clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {mark_strobe, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        template_codes = {7'h05, 7'h3c, 7'h7e, 7'h11};
        failures = 0;
        n_compared = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_scenario();
        custom_scenario();
        sw_scenario();
        template_scenario();
        report_and_stop();
    end
endmodule : custom_tx_pulse_shaper_tb

//--- testbench/dac_model.sv
// Purpose: Converter model at the far side of the shaper
// Assumes: Codes are unsigned magnitudes
// Notes:   Counts a mark when valid falls
`timescale 1ns/100ps
module dac_model
    import pulse_shaper_pkg::*;
(
    input wire logic        aclk,   // Converter clock
    input wire dac_word_t   dac_in, // Word from the shaper
    output logic [3:0][6:0] codes,  // Last code of each phase
    output int              marks   // Marks completed
);
    logic prev_q = 1'b0;
    initial marks = 0;
    // Latch each phase code, count finished marks
    always @(posedge aclk) begin
        if (dac_in.valid) codes[dac_in.phase] <= dac_in.code;
        if (prev_q && !dac_in.valid) marks <= marks + 1;
        prev_q <= dac_in.valid;
    end
endmodule : dac_model

//--- testbench/pulse_shaper_checker.sv
// Purpose: Port assertions for the pulse shaper
// Assumes: Address and data of a write are taken together
// Notes:   Shadows phase codes and the select bit
`timescale 1ns/100ps
`include "pulse_shaper_cfg.svh"
module pulse_shaper_checker
    import pulse_shaper_pkg::*;
(
    input wire logic        aclk,           // Clock
    input wire logic        aresetn,        // Reset, active low
    input wire logic [7:0]  awaddr,         // Write address
    input wire logic        awvalid,        // Address valid
    input wire logic        awready,        // Address ready
    input wire logic [31:0] wdata,          // Write data
    input wire logic        wvalid,         // Data valid
    input wire logic        wready,         // Data ready
    input wire logic        mark_strobe,    // Mark request
    input wire logic [27:0] template_codes, // Template codes
    input wire dac_word_t   dac_out         // Converter word
);
    logic [3:0][6:0] sh_q;
    logic            sel_q;
    logic            sw_start;
    // Mark start written over the bus
    assign sw_start = awvalid && awready && wvalid && wready
        && awaddr == `ADDR_MARK_CTRL && wdata[`MARK_START_BIT];
    // Follow register writes seen on the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_q  <= '0;
            sel_q <= 1'b0;
        end else if (awvalid && awready && wvalid && wready) begin
            if (awaddr[7:4] == 4'h7) sh_q[awaddr[3:2]] <= wdata[6:0];
            if (awaddr == `ADDR_PULSE_ENABLE) sel_q <= wdata[3];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ph_s(logic [1:0] k);
        (dac_out.valid && dac_out.phase == k) [*4];
    endsequence
    chk_phase_order: assert property ($rose(dac_out.valid) |-> ph_s(0)
        ##1 ph_s(1) ##1 ph_s(2) ##1 ph_s(3) ##1 !dac_out.valid)
        else $error("Phase sequence wrong");
    chk_start_delay: assert property ($rose(dac_out.valid)
        |-> $past(mark_strobe, 2) || $past(sw_start, 3))
        else $error("Mark start late");
    chk_phase1_code: assert property (dac_out.valid && sel_q
        && dac_out.phase == 2'd0 |-> dac_out.code == sh_q[0])
        else $error("Phase one code wrong");
    chk_phase2_code: assert property (dac_out.valid && sel_q
        && dac_out.phase == 2'd1 |-> dac_out.code == sh_q[1])
        else $error("Phase two code wrong");
    chk_phase3_code: assert property (dac_out.valid && sel_q
        && dac_out.phase == 2'd2 |-> dac_out.code == sh_q[2])
        else $error("Phase three code wrong");
    chk_phase4_code: assert property (dac_out.valid && sel_q
        && dac_out.phase == 2'd3 |-> dac_out.code == sh_q[3])
        else $error("Phase four code wrong");
    chk_custom_select: assert property (dac_out.valid && sel_q
        |-> dac_out.code == sh_q[dac_out.phase]) else $error("Custom code");
    chk_template_code: assert property (dac_out.valid && !sel_q |->
        dac_out.code == template_codes[7*dac_out.phase +: 7])
        else $error("Template code wrong");
endmodule : pulse_shaper_checker
bind custom_tx_pulse_shaper pulse_shaper_checker chk_inst (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .mark_strobe,
    .template_codes, .dac_out);
